// ==== src/io_expander_consts.vh ====
// Constants for the I2C I/O expander target
`ifndef IO_EXPANDER_CONSTS_VH
`define IO_EXPANDER_CONSTS_VH
`define ADDR_UPPER_BITS 6'h10
`define REG_IN_LO 3'h0
`define REG_IN_HI 3'h1
`define REG_OUT_LO 3'h2
`define REG_OUT_HI 3'h3
`define REG_INV_LO 3'h4
`define REG_INV_HI 3'h5
`define REG_DIR_LO 3'h6
`define REG_DIR_HI 3'h7
`define RST_OUT 8'hFF
`define RST_INV 8'h00
`define RST_DIR 8'hFF
`define RST_CMD 8'h00
`define CLK_FREQ_HZ 25000000
`endif

// ==== src/io_expander_i2c_target.v ====
// I2C target front end and register file of a 16-bit I/O expander
// Function
// R01 - Reset input held low keeps registers and serial state at defaults.
// R02 - Power-on reset holds device in reset until port supply is good.
// R03 - Controller starts transfers only on an idle bus.
// R04 - Start is data falling while clock high; device detects it.
// R05 - Address byte arrives MSB first, last bit is direction.
// R06 - Matching address is acknowledged by pulling data low on ninth clock.
// R07 - Address-select level stays constant between start and stop.
// R08 - Data stable while clock high; changes there are start or stop.
// R09 - Stop is data rising while clock high; device returns idle.
// R10 - Bytes are eight bits plus acknowledge; transmitter releases data first.
// R11 - As receiver, device acknowledges every received byte.
// R12 - Controller acknowledges read bytes except last, which it leaves high.
// R13 - After controller not-acknowledge, device releases the data line.
// R14 - Device answers only 0x20 with select low, 0x21 with select high.
// R15 - Direction bit 1 means read from device, 0 means write.
// R16 - First write byte after address goes to command register; low three select.
// R17 - Controller writes command byte, then repeated start to read.
// R18 - Stored selection applies to later reads until a new command.
// R19 - Command register is writable and readable over the bus; code only writes it, reads return the selected data register.
// R20 - Input port registers ignore writes and return current pin levels.
// R21 - Each written byte moves target to the other register of the pair.
// R22 - Each further read byte comes from the other register of the pair.
// R23 - Direction bit 1 makes pin input, 0 makes pin an output.
// R24 - Input value is sampled pin level XOR polarity inversion bit.
// R25 - Output pins drive the matching output port register bit.
`include "io_expander_consts.vh"
`timescale 1ns/1ns
`default_nettype none
module io_expander_i2c_target #(
    parameter PINS = 16
) (
    input wire CLOCK,
    input wire RESET_N,
    input wire SUPPLY_GOOD,
    input wire ADDR_SEL,
    input wire SCL_IN,
    input wire SDA_IN,
    output reg SDA_OUT,
    output reg SDA_OE,
    input wire [PINS-1:0] EXPANDER_PINS_IN,
    output reg [PINS-1:0] EXPANDER_PINS_OUT,
    output reg [PINS-1:0] EXPANDER_PINS_OE
);

    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_ADDR_ACK = 3'h2;
    localparam ST_WRITE = 3'h3;
    localparam ST_WRITE_ACK = 3'h4;
    localparam ST_READ = 3'h5;
    localparam ST_READ_ACK = 3'h6;

    // Read value of one of the eight byte registers
    function [7:0] reg_byte;
        input [2:0] code;
        input [15:0] ins;
        input [15:0] outs;
        input [15:0] invs;
        input [15:0] dirs;
        begin
            case (code)
                `REG_IN_LO: reg_byte = ins[7:0];
                `REG_IN_HI: reg_byte = ins[15:8];
                `REG_OUT_LO: reg_byte = outs[7:0];
                `REG_OUT_HI: reg_byte = outs[15:8];
                `REG_INV_LO: reg_byte = invs[7:0];
                `REG_INV_HI: reg_byte = invs[15:8];
                `REG_DIR_LO: reg_byte = dirs[7:0];
                default: reg_byte = dirs[15:8];
            endcase
        end
    endfunction

    // Command pointing at the other register of the same pair
    function [7:0] partner;
        input [7:0] code;
        begin
            partner = {code[7:1], ~code[0]};
        end
    endfunction

    // ======================================================
    // Reset combine and input synchronisers
    // ======================================================
    wire arst_n = RESET_N & SUPPLY_GOOD; // see R01 see R02
    reg [2:0] scl_s_q;
    reg [2:0] sda_s_q;
    reg [2:0] adr_s_q;
    reg [PINS-1:0] pin_s1_q;
    reg [PINS-1:0] pin_s2_q;
    reg [PINS-1:0] pin_s3_q;
    reg scl_q;
    reg sda_q;
    reg adr_q;
    reg [PINS-1:0] pin_q;
    always @(posedge CLOCK or negedge arst_n) begin
        if (!arst_n) begin
            scl_s_q <= 3'h7;
            sda_s_q <= 3'h7;
            adr_s_q <= 3'h0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            adr_q <= 1'b0;
            pin_s1_q <= {PINS{1'b0}};
            pin_s2_q <= {PINS{1'b0}};
            pin_s3_q <= {PINS{1'b0}};
            pin_q <= {PINS{1'b0}};
        end else begin
            scl_s_q <= {scl_s_q[1:0], SCL_IN};
            sda_s_q <= {sda_s_q[1:0], SDA_IN};
            adr_s_q <= {adr_s_q[1:0], ADDR_SEL};
            pin_s1_q <= EXPANDER_PINS_IN;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            if (scl_s_q[1] == scl_s_q[2]) begin
                scl_q <= scl_s_q[2];
            end
            if (sda_s_q[1] == sda_s_q[2]) begin
                sda_q <= sda_s_q[2];
            end
            if (adr_s_q[1] == adr_s_q[2]) begin
                adr_q <= adr_s_q[2];
            end
            pin_q <= (pin_s2_q & pin_s3_q) | (pin_q & (pin_s2_q | pin_s3_q));
        end
    end

    // ======================================================
    // Bus condition detection
    // ======================================================
    reg scl_prev_q;
    reg sda_prev_q;
    wire scl_rise = scl_q & ~scl_prev_q;
    wire scl_fall = ~scl_q & scl_prev_q;
    wire start_cond = scl_q & scl_prev_q & sda_prev_q & ~sda_q; // see R04 see R08
    wire stop_cond = scl_q & scl_prev_q & ~sda_prev_q & sda_q; // see R09 see R08

    // ======================================================
    // Register file and serial engine
    // ======================================================
    reg [2:0] state_q;
    reg [3:0] bit_cnt_q;
    reg [7:0] shift_q;
    reg [7:0] cmd_q;
    reg first_q;
    reg rd_q;
    reg [PINS-1:0] out_q;
    reg [PINS-1:0] inv_q;
    reg [PINS-1:0] dir_q;
    wire [PINS-1:0] in_val = pin_q ^ inv_q; // see R24 see R20
    // Current selection and its pair partner
    wire [7:0] rd_byte = reg_byte(cmd_q[2:0], in_val, out_q, inv_q, dir_q); // see R18 see R19
    wire [7:0] rd_alt = reg_byte({cmd_q[2:1], ~cmd_q[0]}, in_val, out_q, inv_q, dir_q); // see R22

    wire [6:0] my_addr = {`ADDR_UPPER_BITS, adr_q}; // see R14

    always @(posedge CLOCK or negedge arst_n) begin
        if (!arst_n) begin // see R01 see R02
            state_q <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            cmd_q <= `RST_CMD;
            first_q <= 1'b0;
            rd_q <= 1'b0;
            out_q <= {(PINS/8){`RST_OUT}};
            inv_q <= {(PINS/8){`RST_INV}};
            dir_q <= {(PINS/8){`RST_DIR}};
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
            SDA_OUT <= 1'b0;
            SDA_OE <= 1'b0;
            EXPANDER_PINS_OUT <= {PINS{1'b0}};
            EXPANDER_PINS_OE <= {PINS{1'b0}};
        end else begin
            scl_prev_q <= scl_q;
            sda_prev_q <= sda_q;
            SDA_OUT <= 1'b0;
            EXPANDER_PINS_OUT <= out_q; // see R25
            EXPANDER_PINS_OE <= ~dir_q; // see R23
            if (stop_cond) begin
                state_q <= ST_IDLE; // see R09
                SDA_OE <= 1'b0;
            end else if (start_cond) begin
                state_q <= ST_ADDR;
                bit_cnt_q <= 4'h0;
                SDA_OE <= 1'b0;
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        SDA_OE <= 1'b0;
                    end
                    ST_ADDR: begin
                        if (scl_rise) begin
                            shift_q <= {shift_q[6:0], sda_q}; // see R05
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end else if (scl_fall && bit_cnt_q == 4'h8) begin
                            if (shift_q[7:1] == my_addr) begin
                                SDA_OE <= 1'b1; // see R06
                                rd_q <= shift_q[0]; // see R15
                                state_q <= ST_ADDR_ACK;
                            end else begin
                                state_q <= ST_IDLE;
                            end
                        end
                    end
                    ST_ADDR_ACK: begin
                        if (scl_fall) begin
                            bit_cnt_q <= 4'h0;
                            if (rd_q) begin
                                SDA_OE <= ~rd_byte[7];
                                shift_q <= {rd_byte[6:0], 1'b0}; // see R18
                                state_q <= ST_READ;
                            end else begin
                                SDA_OE <= 1'b0; // see R10
                                first_q <= 1'b1;
                                state_q <= ST_WRITE;
                            end
                        end
                    end
                    ST_WRITE: begin
                        if (scl_rise) begin
                            shift_q <= {shift_q[6:0], sda_q};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end else if (scl_fall && bit_cnt_q == 4'h8) begin
                            SDA_OE <= 1'b1; // see R11
                            state_q <= ST_WRITE_ACK;
                            first_q <= 1'b0;
                            if (first_q) begin
                                cmd_q <= shift_q; // see R16 see R19
                            end else begin
                                case (cmd_q[2:1])
                                    2'h1: begin
                                        if (cmd_q[0]) begin
                                            out_q[15:8] <= shift_q;
                                        end else begin
                                            out_q[7:0] <= shift_q;
                                        end
                                    end
                                    2'h2: begin
                                        if (cmd_q[0]) begin
                                            inv_q[15:8] <= shift_q;
                                        end else begin
                                            inv_q[7:0] <= shift_q;
                                        end
                                    end
                                    2'h3: begin
                                        if (cmd_q[0]) begin
                                            dir_q[15:8] <= shift_q;
                                        end else begin
                                            dir_q[7:0] <= shift_q;
                                        end
                                    end
                                    default: ; // see R20
                                endcase
                                cmd_q <= partner(cmd_q); // see R21
                            end
                        end
                    end
                    ST_WRITE_ACK: begin
                        if (scl_fall) begin
                            SDA_OE <= 1'b0;
                            bit_cnt_q <= 4'h0;
                            state_q <= ST_WRITE;
                        end
                    end
                    ST_READ: begin
                        if (scl_fall) begin
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                            if (bit_cnt_q == 4'h7) begin
                                SDA_OE <= 1'b0; // see R10
                                state_q <= ST_READ_ACK;
                            end else begin
                                SDA_OE <= ~shift_q[7];
                                shift_q <= {shift_q[6:0], 1'b0};
                            end
                        end
                    end
                    ST_READ_ACK: begin
                        if (scl_rise) begin
                            if (sda_q) begin
                                state_q <= ST_IDLE; // see R13 see R12
                            end
                        end else if (scl_fall) begin
                            bit_cnt_q <= 4'h0;
                            SDA_OE <= ~rd_alt[7];
                            shift_q <= {rd_alt[6:0], 1'b0};
                            cmd_q <= partner(cmd_q); // see R22
                            state_q <= ST_READ;
                        end
                    end
                    default: begin
                        state_q <= ST_IDLE;
                        SDA_OE <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// ==== verification/i2c_ctrl_model.sv ====
// Bus controller model driving clock and open-drain data
`timescale 1ns/1ns
`default_nettype none
module i2c_ctrl_model (
    input wire logic clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_pull
);
    // ====================
    // Bit and frame tasks
    initial begin
        scl = 1'h1;
        sda_pull = 1'h0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic bit_out(input logic b, output logic seen);
        sda_pull <= ~b;
        tick(6);
        scl <= 1'h1;
        tick(6);
        seen = sda_line;
        tick(6);
        scl <= 1'h0;
        tick(6);
    endtask
    task automatic start();
        sda_pull <= 1'h0;
        tick(6);
        scl <= 1'h1;
        tick(6);
        sda_pull <= 1'h1;
        tick(6);
        scl <= 1'h0;
        tick(6);
    endtask
    task automatic stop();
        sda_pull <= 1'h1;
        tick(6);
        scl <= 1'h1;
        tick(6);
        sda_pull <= 1'h0;
        tick(12);
    endtask
    task automatic wr(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_out(b[i], s);
        bit_out(1'h1, ack);
    endtask
    task automatic rd(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_out(1'h1, s);
            d[i] = s;
        end
        bit_out(last, s);
    endtask
endmodule
`default_nettype wire

// ==== verification/io_expander_i2c_target_properties.sv ====
// Port checker for the expander bus target
`timescale 1ns/1ns
`default_nettype none
module io_expander_checker #(
    parameter PINS = 16
) (
    input wire CLOCK,
    input wire RESET_N,
    input wire SUPPLY_GOOD,
    input wire SCL_IN,
    input wire SDA_IN,
    input wire SDA_OUT,
    input wire SDA_OE,
    input wire [PINS-1:0] EXPANDER_PINS_OUT,
    input wire [PINS-1:0] EXPANDER_PINS_OE
);
    // ====================
    // Reset tracking
    wire rst_all_n = RESET_N && SUPPLY_GOOD;
    logic [2:0] run_q;
    always_ff @(posedge CLOCK or negedge rst_all_n) begin
        if (!rst_all_n) run_q <= 3'h0;
        else if (run_q != 3'h7) run_q <= run_q + 3'h1;
    end
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!rst_all_n);
    sequence quiet8; !SDA_OE [*8]; endsequence
    sequence held8; SDA_OE [*8]; endsequence
    // ====================
    // Bus and pin properties
    sda_zero_a: assert property (SDA_OE |-> SDA_OUT == 1'h0) else $error("data driven high");
    reset_quiet_a: assert property (disable iff (1'h0)
        !rst_all_n |-> !SDA_OE && EXPANDER_PINS_OE == '0) else $error("drive during reset");
    oe_edge_a: assert property ($changed(SDA_OE) |-> !SCL_IN) else $error("data moved in clock high");
    ack_hold_a: assert property (SDA_OE && $rose(SCL_IN) |-> held8) else $error("low not held");
    oe_timing_a: assert property ($rose(SDA_OE) |-> $past(SCL_IN, 8)) else $error("drive not after fall");
    stop_idle_a: assert property (SCL_IN && $rose(SDA_IN) |-> quiet8) else $error("drive after stop");
    start_quiet_a: assert property (SCL_IN && $fell(SDA_IN) |-> quiet8) else $error("drive after start");
    pins_steady_a: assert property (run_q == 3'h7 && ($changed(EXPANDER_PINS_OE) ||
        $changed(EXPANDER_PINS_OUT)) |-> !SCL_IN) else $error("pins moved in clock high");
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench for the expander bus target
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic clock = 1'h0;
    logic reset_n = 1'h1;
    logic supply_good = 1'h1;
    logic addr_sel = 1'h0;
    logic [15:0] pins_in = 16'h1234;
    logic scl, sda_pull, a;
    logic [7:0] d;
    wire sda_out, sda_oe;
    wire [15:0] pins_out, pins_oe;
    wire sda_line = !(sda_pull || (sda_oe && !sda_out));
    int n_mismatch = 0;
    int total_checks = 0;
    always #20 clock = ~clock;
    io_expander_i2c_target i_io_expander_i2c_target (.CLOCK(clock), .RESET_N(reset_n), .SUPPLY_GOOD(supply_good),
        .ADDR_SEL(addr_sel), .SCL_IN(scl), .SDA_IN(sda_line), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
        .EXPANDER_PINS_IN(pins_in), .EXPANDER_PINS_OUT(pins_out), .EXPANDER_PINS_OE(pins_oe));
    i2c_ctrl_model i_ctrl (.clk(clock), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));
    // ====================
    // Shared tasks
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wb(input logic [7:0] b);
        i_ctrl.wr(b, a);
        chk("ack", 16'h0000, {15'h0000, a});
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // ====================
    // Scenarios
    task automatic t_defaults();
        chk("pins oe", 16'h0000, pins_oe);
        chk("pins out", 16'hFFFF, pins_out);
    endtask
    task automatic t_address();
        i_ctrl.start();
        i_ctrl.wr(8'h42, a);
        i_ctrl.stop();
        chk("foreign ack", 16'h0001, {15'h0000, a});
        addr_sel <= 1'h1;
        i_ctrl.tick(8);
        i_ctrl.start();
        wb(8'h42);
        i_ctrl.stop();
        i_ctrl.start();
        i_ctrl.wr(8'h40, a);
        i_ctrl.stop();
        chk("low address ack", 16'h0001, {15'h0000, a});
        addr_sel <= 1'h0;
        i_ctrl.tick(8);
    endtask
    task automatic t_write();
        i_ctrl.start();
        wb(8'h40);
        wb(8'h03);
        wb(8'hA5);
        wb(8'h3C);
        i_ctrl.stop();
        i_ctrl.start();
        wb(8'h40);
        wb(8'h07);
        wb(8'h0F);
        wb(8'h00);
        i_ctrl.stop();
        chk("pins out", 16'hA53C, pins_out);
        chk("pins oe", 16'hF0FF, pins_oe);
    endtask
    task automatic t_read();
        i_ctrl.start();
        wb(8'h40);
        wb(8'h02);
        i_ctrl.start();
        wb(8'h41);
        i_ctrl.rd(1'h0, d);
        chk("read first", 16'h003C, {8'h00, d});
        i_ctrl.rd(1'h1, d);
        chk("read second", 16'h00A5, {8'h00, d});
        chk("released", 16'h0000, {15'h0000, sda_oe});
        i_ctrl.stop();
        i_ctrl.start();
        wb(8'h41);
        i_ctrl.rd(1'h1, d);
        chk("read kept", 16'h00A5, {8'h00, d});
        i_ctrl.stop();
    endtask
    task automatic t_inputs();
        i_ctrl.start();
        wb(8'h40);
        wb(8'h04);
        wb(8'hFF);
        wb(8'h00);
        i_ctrl.start();
        wb(8'h40);
        wb(8'h00);
        wb(8'h55);
        i_ctrl.start();
        wb(8'h41);
        i_ctrl.rd(1'h0, d);
        chk("input high", 16'h0012, {8'h00, d});
        i_ctrl.rd(1'h1, d);
        chk("input low", 16'h00CB, {8'h00, d});
        i_ctrl.stop();
        pins_in <= 16'h8E71;
        i_ctrl.tick(8);
        i_ctrl.start();
        wb(8'h41);
        i_ctrl.rd(1'h1, d);
        chk("input live", 16'h008E, {8'h00, d});
        i_ctrl.stop();
    endtask
    // ====================
    // Main sequence and watchdog
    initial begin
        // Falling edge at time zero so the async reset is seen
        reset_n <= 1'h0;
        supply_good <= 1'h0;
        repeat (3) @(posedge clock);
        reset_n <= 1'h1;
        i_ctrl.tick(3);
        supply_good <= 1'h1;
        i_ctrl.tick(8);
        t_defaults();
        t_address();
        t_write();
        t_read();
        t_inputs();
        reset_n <= 1'h0;
        i_ctrl.tick(3);
        reset_n <= 1'h1;
        i_ctrl.tick(8);
        t_defaults();
        close_out();
    end
    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        close_out();
    end
endmodule
bind io_expander_i2c_target io_expander_checker #(.PINS(PINS)) i_checker (.CLOCK(CLOCK), .RESET_N(RESET_N),
    .SUPPLY_GOOD(SUPPLY_GOOD), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
    .EXPANDER_PINS_OUT(EXPANDER_PINS_OUT), .EXPANDER_PINS_OE(EXPANDER_PINS_OE));
`default_nettype wire
